// >>> verilog/driver_lin_fault_defs.vh
// constants for the driver and bus fault control block
`ifndef DRIVER_LIN_FAULT_DEFS_VH
`define DRIVER_LIN_FAULT_DEFS_VH
`define ADDR_MODE 4'h0
`define ADDR_BUSCTL 4'h4
`define ADDR_BUSSTAT 4'h5
`define ADDR_HSCTL 4'h6
`define ADDR_HSSTAT 4'h7
`define ADDR_LSCTL 4'h8
`define ADDR_LSSTAT 4'h9
`define ADDR_IMASK 4'hE
`define ADDR_ISRC 4'hF
`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h1
`define MODE_SLEEP 2'h2
`define MODE_RST 4'hC
`define BUSCTL_RST 4'h1
`define SLEW_20K 2'h1
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`define STUCK_TIME_MS 1000
`define WAKE_FILTER_NS 150000
`define CLK_PERIOD_NS 10
`endif

// >>> verilog/driver_lin_fault_control.v
// driver protection, bus diagnostics and register slave for the driver and bus block
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "driver_lin_fault_defs.vh"
module driver_lin_fault_control #(
  parameter STUCK_CYCLES = (`STUCK_TIME_MS * 1000000) / `CLK_PERIOD_NS,
  parameter WAKE_CYCLES = (`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire rst_b,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pwmInputPin,
  input wire transmitData,
  input wire busRx,
  input wire hsOverTemp,
  input wire hsOpenLoad,
  input wire hsCurrentLimit,
  input wire overVoltage,
  input wire [1:0] lsOverTemp,
  input wire [1:0] lsOpenLoad,
  input wire [1:0] lsCurrentLimit,
  input wire busOverCurrent,
  input wire busOverTemp,
  input wire receiveShort,
  output reg hsDrive,
  output reg [1:0] lsDrive,
  output reg txEnable,
  output reg [1:0] slewSelect,
  output reg dominantLevel,
  output reg pullupConnect,
  output reg wakeThresholdLow,
  output reg irq,
  output reg resetWake
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg [13:0] syncA;
  reg [13:0] syncB;
  always @(posedge clk) begin
    if (!rst_b) begin
      syncA <= 14'h0000;
      syncB <= 14'h0000;
    end else begin
      syncA <= {pwmInputPin, hsOverTemp, hsOpenLoad, hsCurrentLimit, overVoltage, lsOverTemp,
                lsOpenLoad, lsCurrentLimit, busOverCurrent, busOverTemp, receiveShort};
      syncB <= syncA;
    end
  end
  wire pwmS = syncB[13];
  wire hsOtS = syncB[12];
  wire hsOlS = syncB[11];
  wire hsClS = syncB[10];
  wire ovS = syncB[9];
  wire [1:0] lsOtS = syncB[8:7];
  wire [1:0] lsOlS = syncB[6:5];
  wire [1:0] lsClS = syncB[4:3];
  wire busOcS = syncB[2];
  wire busOtS = syncB[1];
  wire shortS = syncB[0];
  reg [1:0] txSync;
  reg [1:0] rxSync;
  reg rxPrev;
  always @(posedge clk) begin
    if (!rst_b) begin
      txSync <= 2'h3;
      rxSync <= 2'h3;
      rxPrev <= 1'b1;
    end else begin
      txSync <= {txSync[0], transmitData};
      rxSync <= {rxSync[0], busRx};
      rxPrev <= rxSync[1];
    end
  end
  wire txHigh = txSync[1];
  wire rxS = rxSync[1];
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  reg awHeld;
  reg wHeld;
  reg [3:0] awIdx;
  reg [3:0] wData;
  reg wStrb0;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire [3:0] curAw = awHeld ? awIdx : s_axi_awaddr[5:2];
  wire [3:0] curW = wHeld ? wData : s_axi_wdata[3:0];
  wire curStrb = wHeld ? wStrb0 : s_axi_wstrb[0];
  wire haveAw = awHeld || (s_axi_awvalid && s_axi_awready);
  wire haveW = wHeld || (s_axi_wvalid && s_axi_wready);
  wire doWrite = haveAw && haveW;
  wire wrMapped = (curAw == `ADDR_MODE) || (curAw == `ADDR_BUSCTL) ||
                  (curAw == `ADDR_HSCTL) || (curAw == `ADDR_LSCTL) || (curAw == `ADDR_IMASK);
  wire wrEn = doWrite && wrMapped && curStrb;
  wire wrHs = wrEn && (curAw == `ADDR_HSCTL);
  wire wrLs = wrEn && (curAw == `ADDR_LSCTL);
  wire doRead = s_axi_arvalid && s_axi_arready;
  wire [3:0] rdIdx = s_axi_araddr[5:2];
  wire rdBus = doRead && (rdIdx == `ADDR_BUSSTAT);
  ////////////////////////////////////////////////////////////////////////////
  // control registers
  reg overvoltageShutdownEnable;
  reg busPullupEnable;
  reg [1:0] powerMode;
  reg receiveOnlyBit;
  reg hsOnBit;
  reg hsPwmSelect;
  reg [1:0] lsOn;
  reg [1:0] lsPwmSel;
  reg [3:0] irqMask;
  reg hsLatchedOff;
  reg lsLatchedOff;
  reg txOtOff;
  reg txShOff;
  reg txDomOff;
  reg [3:0] busStatus;
  reg [3:0] irqSource;
  reg [31:0] stuckCount;
  reg [31:0] wakeCount;
  reg wakeArmed;
  wire lowPower = (powerMode == `MODE_STOP) || (powerMode == `MODE_SLEEP);
  wire hsFault = hsOtS || (overvoltageShutdownEnable && ovS);
  wire lsFault = (|lsOtS) || (overvoltageShutdownEnable && ovS);
  wire stuckNow = (stuckCount >= STUCK_CYCLES - 1) && !txHigh;
  wire busErr = busOcS || busOtS || shortS || stuckNow;
  always @(posedge clk) begin
    if (!rst_b) begin
      overvoltageShutdownEnable <= 1'b1;
      busPullupEnable <= 1'b1;
      powerMode <= `MODE_NORMAL;
      {dominantLevel, receiveOnlyBit, slewSelect} <= `BUSCTL_RST;
      hsOnBit <= 1'b0;
      hsPwmSelect <= 1'b0;
      lsOn <= 2'h0;
      lsPwmSel <= 2'h0;
      irqMask <= 4'h0;
      hsLatchedOff <= 1'b0;
      lsLatchedOff <= 1'b0;
    end else begin
      if (wrEn && curAw == `ADDR_MODE) begin
        overvoltageShutdownEnable <= curW[3];
        busPullupEnable <= curW[2];
        powerMode <= curW[1:0];
      end
      if (wrEn && curAw == `ADDR_BUSCTL) begin
        dominantLevel <= curW[3];
        slewSelect <= curW[1:0];
      end
      if (busErr)
        receiveOnlyBit <= 1'b1;
      else if (wrEn && curAw == `ADDR_BUSCTL)
        receiveOnlyBit <= curW[2];
      if (wrHs) begin
        hsPwmSelect <= curW[2];
        hsOnBit <= curW[0];
      end
      if (wrLs) begin
        lsPwmSel <= curW[3:2];
        lsOn <= curW[1:0];
      end
      if (wrEn && curAw == `ADDR_IMASK)
        irqMask <= curW;
      if (hsFault)
        hsLatchedOff <= 1'b1;
      else if (wrHs)
        hsLatchedOff <= 1'b0;
      if (lsFault)
        lsLatchedOff <= 1'b1;
      else if (wrLs)
        lsLatchedOff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // driver outputs
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : lsChan
      always @(posedge clk) begin
        if (!rst_b)
          lsDrive[ch] <= 1'b0;
        else
          lsDrive[ch] <= lsOn[ch] && (!lsPwmSel[ch] || pwmS) &&
                         !lsLatchedOff && !lsFault && !lowPower;
      end
    end
  endgenerate
  always @(posedge clk) begin
    if (!rst_b) begin
      hsDrive <= 1'b0;
      pullupConnect <= 1'b1;
      wakeThresholdLow <= 1'b0;
    end else begin
      hsDrive <= hsOnBit && (!hsPwmSelect || pwmS) && !hsLatchedOff && !hsFault;
      pullupConnect <= !lowPower || busPullupEnable;
      wakeThresholdLow <= !busPullupEnable;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus diagnostics
  always @(posedge clk) begin
    if (!rst_b) begin
      stuckCount <= 32'h00000000;
      txOtOff <= 1'b0;
      txShOff <= 1'b0;
      txDomOff <= 1'b0;
      busStatus <= 4'h0;
      txEnable <= 1'b0;
    end else begin
      if (txHigh)
        stuckCount <= 32'h00000000;
      else if (!stuckNow)
        stuckCount <= stuckCount + 32'h00000001;
      if (busOtS)
        txOtOff <= 1'b1;
      else if (txHigh)
        txOtOff <= 1'b0;
      if (shortS)
        txShOff <= 1'b1;
      else if (txHigh && (rxS != rxPrev))
        txShOff <= 1'b0;
      if (stuckNow)
        txDomOff <= 1'b1;
      else if (txHigh)
        txDomOff <= 1'b0;
      busStatus[3] <= shortS || (busStatus[3] && !(rdBus && !shortS));
      busStatus[2] <= stuckNow || (busStatus[2] && !(rdBus && txHigh));
      busStatus[1] <= busOtS || (busStatus[1] && !rdBus);
      busStatus[0] <= busOcS || (busStatus[0] && !rdBus);
      txEnable <= !lowPower && !receiveOnlyBit && !txOtOff && !txShOff && !txDomOff &&
                  !busOtS && !shortS && !stuckNow;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources and wake detection
  wire wakeEvent = wakeArmed && rxS;
  always @(posedge clk) begin
    if (!rst_b) begin
      wakeCount <= 32'h00000000;
      wakeArmed <= 1'b0;
      irqSource <= 4'h0;
      irq <= 1'b0;
      resetWake <= 1'b0;
    end else begin
      if (!lowPower || receiveOnlyBit || rxS)
        wakeCount <= 32'h00000000;
      else if (wakeCount < WAKE_CYCLES)
        wakeCount <= wakeCount + 32'h00000001;
      wakeArmed <= lowPower && !receiveOnlyBit && !rxS && (wakeCount >= WAKE_CYCLES);
      irqSource[3] <= hsOtS || (irqSource[3] && !(doRead && rdIdx == `ADDR_ISRC));
      irqSource[2] <= (|lsOtS) || (irqSource[2] && !(doRead && rdIdx == `ADDR_ISRC));
      irqSource[1] <= busErr || (irqSource[1] && !(doRead && rdIdx == `ADDR_ISRC));
      irqSource[0] <= wakeEvent || (irqSource[0] && !(doRead && rdIdx == `ADDR_ISRC));
      irq <= |(irqSource & irqMask);
      resetWake <= wakeEvent && (powerMode == `MODE_SLEEP);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and read mux
  reg [3:0] rdValue;
  reg rdMapped;
  always @* begin
    rdMapped = 1'b1;
    case (rdIdx)
      `ADDR_BUSSTAT: rdValue = busStatus;
      `ADDR_HSSTAT: rdValue = {2'h0, hsOlS || hsOtS, hsClS || hsOtS};
      `ADDR_LSSTAT: rdValue = {lsOlS[1], lsClS[1], lsOlS[0], lsClS[0]};
      `ADDR_ISRC: rdValue = irqSource;
      `ADDR_IMASK: rdValue = irqMask;
      default: begin
        rdValue = 4'h0;
        rdMapped = 1'b0;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 4'h0;
      wData <= 4'h0;
      wStrb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OK;
    end else begin
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `RESP_OK : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld <= 1'b1;
          awIdx <= s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld <= 1'b1;
          wData <= s_axi_wdata[3:0];
          wStrb0 <= s_axi_wstrb[0];
        end
        if (s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {28'h0000000, rdValue};
        s_axi_rresp <= rdMapped ? `RESP_OK : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/driver_lin_fault_props.sv
// property checker for the driver and bus fault control block
`timescale 1ns/10ps
module driver_lin_fault_props #(
  parameter STUCK_CYCLES = 50
) (
  input wire clk,
  input wire rst_b,
  input wire transmitData,
  input wire hsOverTemp,
  input wire overVoltage,
  input wire [1:0] lsOverTemp,
  input wire busOverTemp,
  input wire receiveShort,
  input wire hsDrive,
  input wire [1:0] lsDrive,
  input wire txEnable,
  input wire [1:0] slewSelect,
  input wire resetWake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int lowRun;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
    if (!rst_b || transmitData) lowRun <= 0;
    else if (lowRun < STUCK_CYCLES + 8) lowRun <= lowRun + 1;
  sequence hsHot;
    hsOverTemp [*5];
  endsequence
  sequence lsHot;
    (|lsOverTemp) [*5];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  hs_hot_off_a: assert property (hsHot |-> !hsDrive)
    else $error("high side on while hot");
  ls_hot_off_a: assert property (lsHot |-> lsDrive == 2'h0)
    else $error("low side on while hot");
  volt_off_a: assert property (overVoltage [*5] |-> !hsDrive && lsDrive == 2'h0)
    else $error("driver on during overvoltage");
  reset_slew_a: assert property ($rose(rst_b) |-> slewSelect == 2'h1)
    else $error("slew not default after reset");
  bus_hot_tx_a: assert property (busOverTemp [*5] |-> !txEnable)
    else $error("transmitter on while bus hot");
  rx_short_tx_a: assert property (receiveShort [*5] |-> !txEnable)
    else $error("transmitter on during receive short");
  stuck_tx_a: assert property (lowRun == STUCK_CYCLES + 8 |-> !txEnable)
    else $error("transmitter on while stuck dominant");
  wake_pulse_a: assert property ($rose(resetWake) |=> !resetWake)
    else $error("wake pulse too long");
endmodule
bind driver_lin_fault_control driver_lin_fault_props #(.STUCK_CYCLES(STUCK_CYCLES)) u_props (
  .clk, .rst_b, .transmitData, .hsOverTemp, .overVoltage, .lsOverTemp, .busOverTemp,
  .receiveShort, .hsDrive, .lsDrive, .txEnable, .slewSelect, .resetWake
);

// >>> testbench/host_axi_master.sv
// host model that reaches the registers over the register bus
`timescale 1ns/10ps
module host_axi_master (
  input wire clk,
  output logic [5:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  output wire s_axi_bready,
  input wire s_axi_bvalid,
  output logic [5:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  output wire s_axi_rready,
  input wire s_axi_rvalid
);
  int hangs = 0;
  assign s_axi_bready = 1'b1;
  assign s_axi_rready = 1'b1;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = 0;
    s_axi_wstrb = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) hangs++;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) hangs++;
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking testbench for the driver and bus fault control block
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst_b = 0, pwmInputPin, transmitData, busRx, hsOverTemp, hsOpenLoad;
  logic hsCurrentLimit, overVoltage, busOverCurrent, busOverTemp, receiveShort;
  logic [1:0] lsOverTemp, lsOpenLoad, lsCurrentLimit, lsDrive, slewSelect;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hsDrive, txEnable, irq;
  logic dominantLevel, pullupConnect, wakeThresholdLow, resetWake;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [33:0] expQ[$];
  logic [1:0] bExpQ[$];
  int miscompares = 0, cmpCount = 0, i;
  initial forever #5 clk = ~clk;
  driver_lin_fault_control #(.STUCK_CYCLES(50), .WAKE_CYCLES(5)) u_driver_lin_fault_control (.*);
  host_axi_master u_host_axi_master (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmpCount++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdExp(input logic [5:0] a, input logic [33:0] e);
    expQ.push_back(e);
    u_host_axi_master.rd(a);
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    logic [1:0] r;
    r = (a == 6'h00 || a == 6'h10 || a == 6'h18 || a == 6'h20 || a == 6'h38) ? 2'h0 : 2'h2;
    bExpQ.push_back(r);
    u_host_axi_master.wr(a, d);
  endtask
  task automatic print_verdict;
    miscompares += u_host_axi_master.hangs;
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, bExpQ.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {pwmInputPin, hsOverTemp, hsOpenLoad, hsCurrentLimit, overVoltage, lsOverTemp} <= 0;
    {lsOpenLoad, lsCurrentLimit, busOverCurrent, busOverTemp, receiveShort} <= 0;
    {transmitData, busRx} <= 2'h3;
    void'($urandom(14));
    wt(2);
    rst_b <= 1'b1;
    wt(3);
    chk({slewSelect, pullupConnect, dominantLevel}, 4'h6);
    wr(6'h18, 4'h5);
    wr(6'h20, 4'hF);
    repeat (6) begin
      pwmInputPin <= 1'($urandom);
      wt(6);
      chk({hsDrive, lsDrive}, {3{pwmInputPin}});
    end
    wr(6'h18, 4'h1);
    wr(6'h20, 4'h3);
    pwmInputPin <= 1'b0;
    wt(6);
    chk({hsDrive, lsDrive}, 3'h7);
    for (i = 0; i < 4; i++) begin
      wr(6'h10, {i[0], 1'b0, i[1:0]});
      wt(2);
      chk({dominantLevel, slewSelect}, {i[0], i[1:0]});
    end
    wr(6'h10, 4'h5);
    wt(2);
    chk(txEnable, 1'b0);
    wr(6'h10, 4'h1);
    $display("test pwm and bus control done");
    wr(6'h38, 4'h8);
    hsOverTemp <= 1'b1;
    wt(6);
    chk({hsDrive, irq}, 2'h1);
    rdExp(6'h1C, 34'h3);
    hsOverTemp <= 1'b0;
    wt(6);
    chk(hsDrive, 1'b0);
    rdExp(6'h3C, 34'h8);
    wr(6'h18, 4'h1);
    wt(2);
    chk({hsDrive, irq}, 2'h2);
    wr(6'h38, 4'h4);
    hsOverTemp <= 1'b1;
    wt(6);
    chk(irq, 1'b0);
    hsOverTemp <= 1'b0;
    wt(6);
    rdExp(6'h3C, 34'h8);
    wr(6'h18, 4'h1);
    lsOverTemp <= 2'h2;
    wt(6);
    chk({lsDrive, irq}, 3'h1);
    lsOverTemp <= 2'h0;
    wt(6);
    chk(lsDrive, 2'h0);
    rdExp(6'h3C, 34'h4);
    wr(6'h20, 4'h3);
    wt(2);
    chk({hsDrive, lsDrive}, 3'h7);
    overVoltage <= 1'b1;
    wt(6);
    chk({hsDrive, lsDrive}, 3'h0);
    overVoltage <= 1'b0;
    wt(6);
    chk({hsDrive, lsDrive}, 3'h0);
    wr(6'h18, 4'h1);
    wr(6'h20, 4'h3);
    wt(2);
    chk({hsDrive, lsDrive}, 3'h7);
    lsOpenLoad <= 2'h2;
    lsCurrentLimit <= 2'h1;
    wt(6);
    rdExp(6'h24, 34'h9);
    rdExp(6'h08, {2'h2, 32'h0});
    wr(6'h14, 4'hF);
    {lsOpenLoad, lsCurrentLimit} <= 4'h0;
    $display("test driver faults done");
    wr(6'h38, 4'h2);
    for (i = 0; i < 3; i++) begin
      {receiveShort, busOverTemp, busOverCurrent} <= 3'h1 << i;
      wt(6);
      chk({irq, txEnable}, 2'h2);
      rdExp(6'h14, {i == 2, 1'b0, i == 1, i == 0});
      {receiveShort, busOverTemp, busOverCurrent} <= 3'h0;
      busRx <= 1'b0;
      wt(6);
      busRx <= 1'b1;
      wt(4);
      rdExp(6'h14, {i == 2, 1'b0, i == 1, i == 0});
      rdExp(6'h3C, 34'h2);
      wr(6'h10, 4'h1);
      wt(3);
      chk(txEnable, 1'b1);
    end
    transmitData <= 1'b0;
    wt(60);
    chk(txEnable, 1'b0);
    transmitData <= 1'b1;
    wt(6);
    rdExp(6'h14, 34'h4);
    rdExp(6'h14, 34'h0);
    rdExp(6'h3C, 34'h2);
    wr(6'h10, 4'h1);
    $display("test bus faults done");
    wr(6'h38, 4'h1);
    wr(6'h00, 4'h9);
    wt(3);
    chk({hsDrive, lsDrive, txEnable, pullupConnect}, 5'h10);
    chk(wakeThresholdLow, 1'b1);
    busRx <= 1'b0;
    wt(12);
    busRx <= 1'b1;
    wt(6);
    chk(irq, 1'b1);
    rdExp(6'h3C, 34'h1);
    wr(6'h00, 4'hE);
    busRx <= 1'b0;
    wt(12);
    busRx <= 1'b1;
    for (i = 0; i < 20 && resetWake !== 1'b1; i++) @(posedge clk);
    chk(resetWake, 1'b1);
    wr(6'h10, 4'h2);
    rst_b <= 1'b0;
    wt(2);
    rst_b <= 1'b1;
    wt(3);
    chk(slewSelect, 2'h1);
    $display("test low power and reset done");
    print_verdict;
  end
endmodule
